// *** dpc_defines.svh ***
// Register offsets, field positions, reset values and sizes of the digital port and counter block.
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH

// Register byte offsets; counter n sits at base + n times stride.
`define DPC_OFF_DIR 8'h00
`define DPC_OFF_DOUT 8'h04
`define DPC_OFF_DIN 8'h08
`define DPC_OFF_DSMP 8'h0C
`define DPC_FLD_CFG 2'h0
`define DPC_FLD_VAL 2'h1
`define DPC_FLD_HOLD 2'h2
`define DPC_CNT_GRP_FIRST 2'h1

// Reset values.
`define DPC_DIR_RST 4'hC
`define DPC_DOUT_RST 32'h0000_0000
`define DPC_CFG_RST 20'h0_0000
`define DPC_CNT_RST 32'h0000_0000

// Counter configuration fields.
`define DPC_CFG_W 20
`define DPC_CFG_A_SEL 4:0
`define DPC_CFG_A_EN 5
`define DPC_CFG_B_SEL 10:6
`define DPC_CFG_B_EN 11
`define DPC_CFG_R_SEL 16:12
`define DPC_CFG_R_EN 17
`define DPC_CFG_MODE 19:18

// Sizes.
`define DPC_NCNT 3
`define DPC_NLINE 32
`define DPC_PORT_W 16
`define DPC_GRP_W 8
`define DPC_NGRP 4
`define DPC_CNT_ONE 32'h0000_0001
`define DPC_CNT_MAX 32'hFFFF_FFFF

// Pulse time resolution is one clock period.
`define DPC_CLK_PERIOD_NS 25

// AXI responses.
`define DPC_RESP_OKAY 2'h0
`define DPC_RESP_SLVERR 2'h2

`endif

// *** dpc_pkg.sv ***
// Types shared by the digital port and counter block.
package dpc_pkg;

    typedef enum logic [1:0] {
        dpc_mode_event,
        dpc_mode_updn,
        dpc_mode_quad,
        dpc_mode_ptime
    } dpc_mode_t;

endpackage : dpc_pkg

// *** dpc_cnt_if.sv ***
// Connection between the block top and one counter channel.
`timescale 1ns/1ps

interface dpc_cnt_if;
    logic en;
    dpc_pkg::dpc_mode_t mode;
    logic a;
    logic b;
    logic clr;
    logic smp;
    logic [31:0] value;
    logic [31:0] hold;

    modport ctl (
        output en,
        output mode,
        output a,
        output b,
        output clr,
        output smp,
        input value,
        input hold
    );

    modport cnt (
        input en,
        input mode,
        input a,
        input b,
        input clr,
        input smp,
        output value,
        output hold
    );
endinterface : dpc_cnt_if

// *** dpc_sync.sv ***
// Two flip-flop synchroniser for all digital port lines.
`timescale 1ns/1ps
`include "dpc_defines.svh"

module dpc_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Data
    input wire logic [`DPC_NLINE-1:0] d,
    output logic [`DPC_NLINE-1:0] q
);

    logic [`DPC_NLINE-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : dpc_sync

// *** dpc_counter.sv ***
// One 32-bit counter channel with event, up/down, quadrature and pulse time modes.
`timescale 1ns/1ps
`include "dpc_defines.svh"

module dpc_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Channel
    dpc_cnt_if.cnt bus
);

    logic a_p_r;
    logic b_p_r;
    logic [31:0] run_r;
    logic seen_r;
    logic a_rise;
    logic chg_a;
    logic chg_b;

    assign a_rise = bus.a && !a_p_r;
    assign chg_a = bus.a ^ a_p_r;
    assign chg_b = bus.b ^ b_p_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            a_p_r <= 1'b0;
            b_p_r <= 1'b0;
        end else begin
            a_p_r <= bus.a;
            b_p_r <= bus.b;
        end
    end

    // Count value; the external clear overrides everything else.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus.value <= `DPC_CNT_RST;
        end else if (bus.clr) begin
            bus.value <= `DPC_CNT_RST;
        end else if (bus.en) begin
            unique case (bus.mode)
                dpc_pkg::dpc_mode_event: begin
                    if (a_rise) begin
                        bus.value <= bus.value + `DPC_CNT_ONE;
                    end
                end
                dpc_pkg::dpc_mode_updn: begin
                    if (a_rise) begin
                        bus.value <= bus.b ? bus.value - `DPC_CNT_ONE : bus.value + `DPC_CNT_ONE;
                    end
                end
                dpc_pkg::dpc_mode_quad: begin
                    if (chg_a && !chg_b) begin
                        bus.value <= (bus.a ^ bus.b) ? bus.value + `DPC_CNT_ONE : bus.value - `DPC_CNT_ONE;
                    end else if (chg_b && !chg_a) begin
                        bus.value <= (bus.a ^ bus.b) ? bus.value - `DPC_CNT_ONE : bus.value + `DPC_CNT_ONE;
                    end
                end
                dpc_pkg::dpc_mode_ptime: begin
                    if (a_rise && seen_r) begin
                        bus.value <= run_r;
                    end
                end
            endcase
        end
    end

    // Interval timer between rising edges; saturates at the top of its range.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_r <= `DPC_CNT_RST;
            seen_r <= 1'b0;
        end else if (bus.clr || !bus.en || bus.mode != dpc_pkg::dpc_mode_ptime) begin
            run_r <= `DPC_CNT_RST;
            seen_r <= 1'b0;
        end else if (a_rise) begin
            run_r <= `DPC_CNT_ONE;
            seen_r <= 1'b1;
        end else if (run_r != `DPC_CNT_MAX) begin
            run_r <= run_r + `DPC_CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus.hold <= `DPC_CNT_RST;
        end else if (bus.smp) begin
            bus.hold <= bus.value;
        end
    end

endmodule : dpc_counter

// *** dpc_top.sv ***
// Digital ports and counters with an AXI4-Lite register slave.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dpc_defines.svh"

module dpc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Sample instant from the analog sampler
    input wire logic sample_stb,
    // Digital port A
    input wire logic [`DPC_PORT_W-1:0] pa_i,
    output logic [`DPC_PORT_W-1:0] pa_o,
    output logic [`DPC_PORT_W-1:0] pa_oe,
    // Digital port B
    input wire logic [`DPC_PORT_W-1:0] pb_i,
    output logic [`DPC_PORT_W-1:0] pb_o,
    output logic [`DPC_PORT_W-1:0] pb_oe
);

    // ****************************************
    // Registers and internal signals
    // ****************************************

    // Direction of each group of eight lines while reset is held.
    localparam logic [`DPC_NGRP-1:0] dir_rst = `DPC_DIR_RST;

    logic [`DPC_NGRP-1:0] dir_r;
    logic [31:0] dout_r;
    logic [`DPC_NLINE-1:0] oe_r;
    logic [`DPC_NLINE-1:0] pins_s;
    logic [`DPC_NLINE-1:0] din_smp_r;
    logic [`DPC_CFG_W-1:0] cfg_r [`DPC_NCNT];
    logic [31:0] cnt_val [`DPC_NCNT];
    logic [31:0] cnt_hold [`DPC_NCNT];

    logic aw_have_r;
    logic [7:0] awaddr_r;
    logic w_have_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_wr;
    logic wr_ok;
    logic [1:0] wr_idx;
    logic wr_cnt;

    logic [31:0] rd_nxt;
    logic rd_err;

    // ****************************************
    // Pin synchronisation and sampling
    // ****************************************

    dpc_sync u_sync (
        .clk (clk),
        .rst_b (rst_b),
        .d ({pb_i, pa_i}),
        .q (pins_s)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            din_smp_r <= '0;
        end else if (sample_stb) begin
            din_smp_r <= pins_s;
        end
    end

    // ****************************************
    // Output drivers
    // ****************************************

    genvar gl;
    generate
        for (gl = 0; gl < `DPC_NLINE; gl++) begin : g_oe
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    oe_r[gl] <= dir_rst[gl / `DPC_GRP_W];
                end else begin
                    oe_r[gl] <= dir_r[gl / `DPC_GRP_W];
                end
            end
        end
    endgenerate

    assign pa_oe = oe_r[`DPC_PORT_W-1:0];
    assign pb_oe = oe_r[`DPC_NLINE-1:`DPC_PORT_W];
    assign pa_o = dout_r[`DPC_PORT_W-1:0];
    assign pb_o = dout_r[`DPC_NLINE-1:`DPC_PORT_W];

    // ****************************************
    // Counter channels
    // ****************************************

    // Counter inputs come from the synchronised pins, so a pulse is seen only when it stands
    // at least one clock high and one clock low.
    genvar gc;
    generate
        for (gc = 0; gc < `DPC_NCNT; gc++) begin : g_cnt
            dpc_cnt_if u_if ();

            assign u_if.en = cfg_r[gc][`DPC_CFG_A_EN];
            assign u_if.mode = dpc_pkg::dpc_mode_t'(cfg_r[gc][`DPC_CFG_MODE]);
            assign u_if.a = pins_s[cfg_r[gc][`DPC_CFG_A_SEL]];
            assign u_if.b = cfg_r[gc][`DPC_CFG_B_EN] & pins_s[cfg_r[gc][`DPC_CFG_B_SEL]];
            assign u_if.clr = cfg_r[gc][`DPC_CFG_R_EN] & pins_s[cfg_r[gc][`DPC_CFG_R_SEL]];
            assign u_if.smp = sample_stb;
            assign cnt_val[gc] = u_if.value;
            assign cnt_hold[gc] = u_if.hold;

            dpc_counter u_cnt (
                .clk (clk),
                .rst_b (rst_b),
                .bus (u_if.cnt)
            );
        end
    endgenerate

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // A new write waits while the previous response is still unanswered.
    assign do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_cnt = awaddr_r[7:6] == 2'h0 && awaddr_r[5:4] != 2'h0 && awaddr_r[3:2] == `DPC_FLD_CFG
        && awaddr_r[1:0] == 2'h0;
    assign wr_idx = awaddr_r[5:4] - `DPC_CNT_GRP_FIRST;
    assign wr_ok = awaddr_r == `DPC_OFF_DIR || awaddr_r == `DPC_OFF_DOUT || wr_cnt;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_wr) begin
            aw_have_r <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            w_have_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_wr) begin
            w_have_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DPC_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `DPC_RESP_OKAY : `DPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // Writable registers
    // ****************************************

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dir_r <= `DPC_DIR_RST;
        end else if (do_wr && awaddr_r == `DPC_OFF_DIR && wstrb_r[0]) begin
            dir_r <= wdata_r[`DPC_NGRP-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dout_r <= `DPC_DOUT_RST;
        end else if (do_wr && awaddr_r == `DPC_OFF_DOUT) begin
            dout_r <= merge(dout_r, wdata_r, wstrb_r);
        end
    end

    genvar gr;
    generate
        for (gr = 0; gr < `DPC_NCNT; gr++) begin : g_cfg
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    cfg_r[gr] <= `DPC_CFG_RST;
                end else if (do_wr && wr_cnt && wr_idx == 2'(gr)) begin
                    cfg_r[gr] <= `DPC_CFG_W'(merge(32'(cfg_r[gr]), wdata_r, wstrb_r));
                end
            end
        end
    endgenerate

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************

    // Read data are latched when the address is taken and stand until rready.
    always_comb begin
        logic [1:0] idx;
        idx = s_axi_araddr[5:4] - `DPC_CNT_GRP_FIRST;
        rd_nxt = 32'h0000_0000;
        rd_err = 1'b0;
        if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[7:6] != 2'h0) begin
            rd_err = 1'b1;
        end else if (s_axi_araddr[5:4] == 2'h0) begin
            unique case (s_axi_araddr[3:2])
                2'h0: rd_nxt = {28'h000_0000, dir_r};
                2'h1: rd_nxt = dout_r;
                2'h2: rd_nxt = pins_s;
                2'h3: rd_nxt = din_smp_r;
            endcase
        end else begin
            unique case (s_axi_araddr[3:2])
                `DPC_FLD_CFG: rd_nxt = {12'h000, cfg_r[idx]};
                `DPC_FLD_VAL: rd_nxt = cnt_val[idx];
                `DPC_FLD_HOLD: rd_nxt = cnt_hold[idx];
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DPC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_nxt;
            s_axi_rresp <= rd_err ? `DPC_RESP_SLVERR : `DPC_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : dpc_top

// *** dpc_top_asserts.sv ***
// Port and register bus checks for the digital port and counter block.
`timescale 1ns/1ps
`include "dpc_defines.svh"

module dpc_top_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Digital ports
    input wire logic [15:0] pa_o,
    input wire logic [15:0] pa_oe,
    input wire logic [15:0] pb_o,
    input wire logic [15:0] pb_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    grp_whole_a: assert property (
        pa_oe[7:0] inside {8'h00, 8'hFF} && pa_oe[15:8] inside {8'h00, 8'hFF} &&
        pb_oe[7:0] inside {8'h00, 8'hFF} && pb_oe[15:8] inside {8'h00, 8'hFF}) else $error("Group split.");
    rst_dir_a: assert property (
        $rose(rst_b) |-> pa_oe == 16'h0000 && pb_oe == 16'hFFFF) else $error("Bad reset direction.");
    dir_hold_a: assert property (
        $changed({pa_oe, pb_oe}) |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("Direction moved alone.");
    dout_hold_a: assert property (
        $changed({pa_o, pb_o}) |-> $rose(s_axi_bvalid)) else $error("Outputs moved alone.");
    wr_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write answer late.");
    b_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("Response dropped.");
    rd_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("Read answer late.");
    rd_err_a: assert property (
        s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:4] > 4'h3 || s_axi_araddr[1:0] != 2'h0 ||
        (s_axi_araddr[7:4] != 4'h0 && s_axi_araddr[3:2] == 2'h3))
        |=> s_axi_rresp == `DPC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("Unmapped read accepted.");
endmodule : dpc_top_asserts

bind dpc_top dpc_top_asserts u_chk (.clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .pa_o, .pa_oe, .pb_o, .pb_oe);

// *** dpc_field.sv ***
// Field side model: drives input lines, pulses and encoder phases.
`timescale 1ns/1ps

module dpc_field (
    // Clock
    input wire logic clk,
    // Device pins
    input wire logic [15:0] pa_o,
    input wire logic [15:0] pa_oe,
    input wire logic [15:0] pb_o,
    input wire logic [15:0] pb_oe,
    output logic [15:0] pa_i,
    output logic [15:0] pb_i
);
    logic [31:0] oe;
    logic [31:0] lvl;
    logic [31:0] ext_r = 32'h0;
    logic [31:0] drv_r = 32'h0;
    logic tog_r = 1'b0;
    int ph = 0;

    always @(posedge clk) begin
        tog_r <= ~tog_r;
    end

    // Device outputs win; an undriven line changes every cycle.
    assign oe = {pb_oe, pa_oe};
    assign lvl = (oe & {pb_o, pa_o}) | (~oe & drv_r & ext_r) | (~oe & ~drv_r & {32{tog_r}});
    assign pa_i = lvl[15:0];
    assign pb_i = lvl[31:16];

    task automatic set_all(input logic [31:0] d, input logic [31:0] v);
        @(posedge clk);
        drv_r <= d;
        ext_r <= v;
    endtask : set_all

    task automatic set_line(input int i, input logic v);
        @(posedge clk);
        ext_r[i] <= v;
    endtask : set_line

    task automatic pulses(input int i, input int n, input int hi, input int lo);
        repeat (n) begin
            set_line(i, 1'b1);
            repeat (hi - 1) @(posedge clk);
            set_line(i, 1'b0);
            repeat (lo - 1) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask : pulses

    // Phase order 00, 10, 11, 01 has line a leading.
    task automatic quad(input int ia, input int ib, input int n, input logic up);
        repeat (n) begin
            ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
            @(posedge clk);
            ext_r[ia] <= (ph == 1 || ph == 2);
            ext_r[ib] <= (ph >= 2);
            repeat (3) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask : quad
endmodule : dpc_field

// *** dpc_tb_top.sv ***
// Self-checking bench for the digital port and counter block.
`timescale 1ns/1ps
`include "dpc_defines.svh"

module dpc_tb_top;
    logic clk = 1'b0;
    logic rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sample_stb;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    logic [15:0] pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe;
    int fail_count = 0;
    int tests_run = 0;

    always #12.5 clk = ~clk;

    dpc_top u_dut (.clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .sample_stb, .pa_i, .pa_o, .pa_oe, .pb_i, .pb_o, .pb_oe);
    dpc_field u_fld (.clk, .pa_o, .pa_oe, .pb_o, .pb_oe, .pa_i, .pb_i);

    // ********
    // Bus tasks
    // ********
    task automatic test_done();
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 100) begin
            chk(n, 0);
            test_done();
        end
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw_ok;
        logic w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            tick(n);
            if (s_axi_awready && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) begin
            tick(n);
        end
        s_axi_bready <= 1'b1;
        @(posedge clk);
        resp_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            tick(n);
        end while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) begin
            tick(n);
        end
        s_axi_rready <= 1'b1;
        @(posedge clk);
        resp_q = s_axi_rresp;
        chk(s_axi_rdata, e);
        s_axi_rready <= 1'b0;
    endtask : rdc

    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        chk({pb_oe, pa_oe}, 32'hFFFF0000);
        rdc(`DPC_OFF_DIR, 32'hC);
        rdc(8'h3C, 32'h0);
        chk({30'h0, resp_q}, {30'h0, `DPC_RESP_SLVERR});
        wr(`DPC_OFF_DIN, 32'hFFFF_FFFF);
        chk({30'h0, resp_q}, {30'h0, `DPC_RESP_SLVERR});
    endtask : t_reset

    task automatic t_din();
        u_fld.set_all(32'hFFFFFFFF, 32'hA5A50F0F);
        repeat (6) @(posedge clk);
        sample_stb <= 1'b1;
        @(posedge clk);
        sample_stb <= 1'b0;
        u_fld.set_all(32'hFFFFFFFF, 32'h1234);
        repeat (6) @(posedge clk);
        rdc(`DPC_OFF_DSMP, 32'h0F0F);
        rdc(`DPC_OFF_DIN, 32'h1234);
    endtask : t_din

    task automatic t_dir();
        wr(`DPC_OFF_DIR, 32'h5);
        chk({30'h0, resp_q}, {30'h0, `DPC_RESP_OKAY});
        chk({pb_oe, pa_oe}, 32'h00FF00FF);
        wr(`DPC_OFF_DOUT, 32'h1234ABCD);
        chk({pb_o, pa_o}, 32'h1234ABCD);
        s_axi_wstrb <= 4'h2;
        wr(`DPC_OFF_DOUT, 32'hFFFF_FFFF);
        s_axi_wstrb <= 4'hF;
        chk({pb_o, pa_o}, 32'h1234FFCD);
        rdc(`DPC_OFF_DIN, 32'h003412CD);
        wr(`DPC_OFF_DIR, 32'h0);
        u_fld.set_all(32'hFFFFFFFF, 32'h0);
    endtask : t_dir

    task automatic t_event();
        wr(8'h10, 32'h3);
        u_fld.pulses(3, 3, 3, 3);
        rdc(8'h14, 32'h0);
        wr(8'h10, 32'h23);
        u_fld.pulses(3, 5, 2, 2);
        rdc(8'h14, 32'h5);
        sample_stb <= 1'b1;
        @(posedge clk);
        sample_stb <= 1'b0;
        u_fld.pulses(3, 2, 2, 3);
        rdc(8'h18, 32'h5);
        rdc(8'h14, 32'h7);
        wr(8'h10, 32'h24023);
        u_fld.set_line(4, 1'b1);
        u_fld.pulses(3, 2, 2, 2);
        rdc(8'h14, 32'h0);
        u_fld.set_line(4, 1'b0);
    endtask : t_event

    task automatic t_count();
        wr(8'h20, 32'h409A5);
        u_fld.pulses(5, 3, 2, 4);
        rdc(8'h24, 32'h3);
        u_fld.set_line(6, 1'b1);
        u_fld.pulses(5, 5, 3, 2);
        rdc(8'h24, 32'hFFFFFFFE);
        wr(8'h30, 32'h80D74);
        u_fld.quad(20, 21, 8, 1'b1);
        rdc(8'h34, 32'h8);
        u_fld.quad(20, 21, 12, 1'b0);
        rdc(8'h34, 32'hFFFFFFFC);
        wr(8'h10, 32'hC0023);
        u_fld.pulses(3, 3, 4, 6);
        rdc(8'h14, 32'hA);
        u_fld.pulses(3, 2, 8, 9);
        rdc(8'h14, 32'h11);
    endtask : t_count

    initial begin
        rst_b <= 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sample_stb} <= 6'h0;
        s_axi_awaddr <= 8'h0;
        s_axi_araddr <= 8'h0;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'hF;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_din();
        t_dir();
        t_event();
        t_count();
        test_done();
    end
endmodule : dpc_tb_top
